//--- core/clk_delay_ctrl.sv
// core: sample clock delay control and divider sysref phase report
`timescale 1ns/1ps
`default_nettype none
module clk_delay_ctrl
  import clk_delay_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        sysref,
  output logic             div_realign,
  output logic      [3:0]  div_phase,
  output logic             fine_en,
  output logic             superfine_en,
  output logic             low_jitter,
  output logic      [7:0]  fine_steps,
  output logic      [7:0]  superfine_steps,
  output logic      [18:0] delay_fs
);

  logic [7:0] sync_ctrl;
  logic [3:0] status;
  logic [2:0] mode;
  logic [7:0] superfine;
  logic [7:0] fine;
  logic [3:0] offset;
  logic       wr_pend;
  logic [9:0] wr_idx;
  logic       sysref_q;

  // bus decode; always zero wait and OKAY
  wire       addr_ok = hsel & htrans[1] & hready;
  wire       in_map  = haddr[31:12] == 20'h0;
  wire [9:0] a_idx   = haddr[11:2];
  wire       rd_take = addr_ok & ~hwrite;
  wire       wr_take = addr_ok & hwrite & in_map;

  wire wr_sync = wr_pend & (wr_idx == IDX_SYNC_CTRL);
  wire wr_mode = wr_pend & (wr_idx == IDX_MODE);
  wire wr_sf   = wr_pend & (wr_idx == IDX_SUPERFINE);
  wire wr_fine = wr_pend & (wr_idx == IDX_FINE);
  wire wr_ofs  = wr_pend & (wr_idx == IDX_OFFSET);

  // reserved bits [6:4] of sync control stay zero
  wire [7:0] next_sync_ctrl = wr_sync ? (hwdata[7:0] & 8'h8f) : sync_ctrl;
  wire [2:0] next_mode      = wr_mode ? hwdata[2:0] : mode;
  wire [7:0] next_superfine = wr_sf ? hwdata[7:0] : superfine;
  wire [7:0] next_fine      = wr_fine ? hwdata[7:0] : fine;
  wire [3:0] next_offset    = wr_ofs ? hwdata[3:0] : offset;

  // sysref capture and skew window check
  wire       capture_en = sync_ctrl[CAP_EN_BIT];
  wire [1:0] neg_win    = sync_ctrl[NEG_WIN_MSB:NEG_WIN_LSB];
  wire [1:0] pos_win    = sync_ctrl[POS_WIN_MSB:POS_WIN_LSB];
  wire       sref_edge  = sysref & ~sysref_q;
  wire       cap        = sref_edge & capture_en;
  wire [4:0] neg_sum    = {1'b0, div_phase} + {3'b0, neg_win};
  // edges within the windows leave the divider alone
  wire       in_win     = (div_phase <= {2'b0, pos_win}) | neg_sum[4];
  wire       realign    = cap & ~in_win;
  // an ignored edge reports its phase applied to the offset
  wire [3:0] next_status =
    ~cap    ? status :
    realign ? offset :
              4'(offset + div_phase);

  // delay mode decode; codes 1, 5, 7 fall through as no delay
  wire m_f16  = mode == DLY_FINE16;
  wire m_lj   = mode == DLY_FINE16_LJ;
  wire m_full = mode == DLY_FINE_FULL;
  wire m_sf   = mode == DLY_FINE_SF;
  wire fine_act = m_f16 | m_lj | m_full | m_sf;
  wire sf_act   = m_f16 | m_sf;
  wire lim16    = m_f16 | m_lj;
  // out-of-range codes are clamped so the delay line never overruns
  wire [7:0] fine_cap = lim16 ? FINE_LIM_LOW : FINE_LIM_FULL;
  wire [7:0] fine_val = (fine > fine_cap) ? fine_cap : fine;
  wire [7:0] sf_val   = (superfine > SF_LIM) ? SF_LIM : superfine;
  wire [7:0] next_fine_steps = fine_act ? fine_val : 8'h00;
  wire [7:0] next_sf_steps   = sf_act ? sf_val : 8'h00;
  wire [18:0] next_delay_fs =
    19'(19'(next_fine_steps) * FINE_STEP_FS) +
    19'(19'(next_sf_steps) * SF_STEP_FS);

  // read mux sees this cycle's write, so read after write is coherent
  wire [7:0] rd_byte =
    (a_idx == IDX_SYNC_CTRL) ? next_sync_ctrl :
    (a_idx == IDX_STATUS)    ? {4'h0, next_status} :
    (a_idx == IDX_MODE)      ? {5'h0, next_mode} :
    (a_idx == IDX_SUPERFINE) ? next_superfine :
    (a_idx == IDX_FINE)      ? next_fine :
    (a_idx == IDX_OFFSET)    ? {4'h0, next_offset} : 8'h00;
  wire [31:0] next_rdata = in_map ? {24'h0, rd_byte} : 32'h0;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_idx  <= 10'h0;
      hrdata  <= 32'h0;
    end else begin
      wr_pend <= wr_take;
      wr_idx  <= a_idx;
      if (rd_take) begin
        hrdata <= next_rdata;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_ctrl <= SYNC_CTRL_RST;
      mode      <= MODE_RST;
      superfine <= SUPERFINE_RST;
      fine      <= FINE_RST;
      offset    <= OFFSET_RST;
    end else begin
      sync_ctrl <= next_sync_ctrl;
      mode      <= next_mode;
      superfine <= next_superfine;
      fine      <= next_fine;
      offset    <= next_offset;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sysref_q    <= 1'b0;
      status      <= STATUS_RST;
      div_phase   <= DIV_PHASE_RST;
      div_realign <= 1'b0;
    end else begin
      sysref_q    <= sysref;
      status      <= next_status;
      div_phase   <= realign ? 4'h0 : 4'(div_phase + DIV_STEP);
      div_realign <= realign;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fine_en         <= 1'b0;
      superfine_en    <= 1'b0;
      low_jitter      <= 1'b0;
      fine_steps      <= 8'h00;
      superfine_steps <= 8'h00;
      delay_fs        <= 19'h0;
    end else begin
      fine_en         <= fine_act;
      superfine_en    <= sf_act;
      low_jitter      <= m_lj;
      fine_steps      <= next_fine_steps;
      superfine_steps <= next_sf_steps;
      delay_fs        <= next_delay_fs;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_status_zero_win: assert property (
    cap && neg_win == 2'h0 && pos_win == 2'h0 |=> status == $past(offset))
    else $error("status differs from offset with zero windows");

  a_status_in_win: assert property (
    cap && in_win |=> status == 4'($past(offset) + $past(div_phase)))
    else $error("ignored edge phase not reported");

  a_divider_align: assert property (
    cap && !in_win |=> div_realign && div_phase == 4'h0
      ##1 div_phase == DIV_STEP)
    else $error("divider not realigned outside window");

  a_status_hold: assert property (
    !capture_en |=> $stable(status))
    else $error("status moved while capture disabled");

  a_no_delay: assert property (
    !(m_f16 || m_lj || m_full || m_sf) |=>
      fine_steps == 8'h00 && superfine_steps == 8'h00 && !fine_en)
    else $error("delay applied in no-delay mode");

  a_fine_low_lim: assert property (
    m_f16 || m_lj |=> fine_steps <= FINE_LIM_LOW && fine_en)
    else $error("fine steps exceed 16 in limited mode");

  a_low_jitter: assert property (
    m_lj |=> low_jitter && superfine_steps == 8'h00)
    else $error("lowest jitter variant not selected");

  a_fine_full: assert property (
    m_full && fine <= FINE_LIM_FULL |=> fine_steps == $past(fine))
    else $error("full fine range not applied");

  a_superfine_on: assert property (
    m_sf && superfine <= SF_LIM |=>
      superfine_steps == $past(superfine) && superfine_en)
    else $error("super-fine steps not applied");

  a_superfine_off: assert property (
    !(m_f16 || m_sf) |=> superfine_steps == 8'h00 && !superfine_en)
    else $error("super-fine used outside its modes");

  a_delay_sum: assert property (
    delay_fs == 19'(19'(fine_steps) * FINE_STEP_FS) +
                19'(19'(superfine_steps) * SF_STEP_FS))
    else $error("delay total mismatch");

  a_status_read: assert property (
    rd_take && in_map && a_idx == IDX_STATUS |=> hrdata == {28'h0, status})
    else $error("status read mismatch");

  // register writes land at the end of the data phase
  a_mode_write: assert property (
    wr_mode |=> mode == $past(hwdata[2:0]))
    else $error("mode write lost");

  a_fine_write: assert property (
    wr_fine |=> fine == $past(hwdata[7:0]))
    else $error("fine step write lost");

  a_sf_write: assert property (
    wr_sf |=> superfine == $past(hwdata[7:0]))
    else $error("super-fine step write lost");

  a_offset_write: assert property (
    wr_ofs |=> offset == $past(hwdata[3:0]))
    else $error("phase offset write lost");

  a_sync_write: assert property (
    wr_sync |=> sync_ctrl == ($past(hwdata[7:0]) & 8'h8f))
    else $error("sync control write lost");

  a_status_only_cap: assert property (
    !cap |=> $stable(status))
    else $error("status moved without a capture");

  a_rdata_hold: assert property (
    !rd_take |=> $stable(hrdata))
    else $error("read data changed outside a read");

  a_phase_step: assert property (
    !realign |=> div_phase == 4'($past(div_phase) + DIV_STEP))
    else $error("divider phase did not advance");

  a_realign_pulse: assert property (
    div_realign |=> !div_realign)
    else $error("realign pulse longer than one cycle");

  a_cap_off: assert property (
    sref_edge && !capture_en |=> !div_realign)
    else $error("divider realigned with capture disabled");

  a_fine_clamp: assert property (
    (m_full || m_sf) && fine > FINE_LIM_FULL |=> fine_steps == FINE_LIM_FULL)
    else $error("fine steps beyond 192 not clamped");

  a_sf_range: assert property (
    superfine_steps <= SF_LIM)
    else $error("super-fine steps beyond 128");

  a_sf_limited: assert property (
    m_f16 && superfine <= SF_LIM |=> superfine_steps == $past(superfine))
    else $error("super-fine steps not applied in mode 2");

  a_lj_off: assert property (
    !m_lj |=> !low_jitter)
    else $error("lowest jitter set outside its mode");

  c_edge_disabled: cover property (sref_edge && !capture_en);
  c_edge_ignored:  cover property (cap && in_win && div_phase != 4'h0);
  c_edge_realign:  cover property (realign);
  c_superfine_use: cover property (m_sf && superfine_steps != 8'h00);
  c_status_read:   cover property (rd_take && a_idx == IDX_STATUS);

endmodule
`default_nettype wire

//--- inc/clk_delay_pkg.sv
// package: register map, field layout and constants for the clock delay block
`default_nettype none
package clk_delay_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_SYNC_CTRL = 10'h10a;
  localparam logic [9:0] IDX_STATUS    = 10'h10b;
  localparam logic [9:0] IDX_MODE      = 10'h110;
  localparam logic [9:0] IDX_SUPERFINE = 10'h111;
  localparam logic [9:0] IDX_FINE      = 10'h112;
  localparam logic [9:0] IDX_OFFSET    = 10'h129;

  // sync control field positions
  localparam int CAP_EN_BIT  = 7;
  localparam int NEG_WIN_MSB = 3;
  localparam int NEG_WIN_LSB = 2;
  localparam int POS_WIN_MSB = 1;
  localparam int POS_WIN_LSB = 0;

  // values after reset
  localparam logic [7:0] SYNC_CTRL_RST = 8'h00;
  localparam logic [3:0] STATUS_RST    = 4'h0;
  localparam logic [2:0] MODE_RST      = 3'h0;
  localparam logic [7:0] SUPERFINE_RST = 8'h00;
  localparam logic [7:0] FINE_RST      = 8'h00;
  localparam logic [3:0] OFFSET_RST    = 4'h0;
  localparam logic [3:0] DIV_PHASE_RST = 4'h0;

  // step limits
  localparam logic [7:0] FINE_LIM_LOW  = 8'h10;
  localparam logic [7:0] FINE_LIM_FULL = 8'hc0;
  localparam logic [7:0] SF_LIM        = 8'h80;

  // step sizes in femtoseconds
  localparam logic [18:0] FINE_STEP_FS = 19'h006bd;
  localparam logic [18:0] SF_STEP_FS   = 19'h000fa;

  // divider phase advance per clk_sys cycle, in half device-clock cycles
  localparam logic [3:0] DIV_STEP = 4'h2;

  typedef enum logic [2:0] {
    DLY_NONE      = 3'h0,
    DLY_FINE16    = 3'h2,
    DLY_FINE16_LJ = 3'h3,
    DLY_FINE_FULL = 3'h4,
    DLY_FINE_SF   = 3'h6
  } delay_mode_t;

endpackage
`default_nettype wire

//--- tb/testbench.sv
// testbench: random and corner checks of the clock delay control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
  err_total++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
  end end
module testbench;
  import clk_delay_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        sysref = 1'b0;
  logic        div_realign;
  logic [3:0]  div_phase;
  logic        fine_en;
  logic        superfine_en;
  logic        low_jitter;
  logic [7:0]  fine_steps;
  logic [7:0]  superfine_steps;
  logic [18:0] delay_fs;
  logic [31:0] rd;
  logic [7:0]  f;
  logic [7:0]  s;
  logic [3:0]  ofs;
  int          err_total = 0;
  int          n_tests = 0;
  int          seed;
  int          cyc = 0;
  int          t_cap;
  int          a_edge;
  logic [3:0]  ph;
  logic        win;

  always #4 clk_sys = ~clk_sys;

  // edge count, read before its own update at every edge
  always @(posedge clk_sys) cyc <= cyc + 1;

  clk_delay_ctrl clk_delay_ctrl_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sysref(sysref), .div_realign(div_realign),
    .div_phase(div_phase),
    .fine_en(fine_en), .superfine_en(superfine_en), .low_jitter(low_jitter),
    .fine_steps(fine_steps), .superfine_steps(superfine_steps),
    .delay_fs(delay_fs));

  // expected applied steps: clamped per mode, zero where the mode ignores them
  function automatic logic [7:0] exp_fine(input int m, input logic [7:0] v);
    if (m == 2 || m == 3) return (v > 8'h10) ? 8'h10 : v;
    if (m == 4 || m == 6) return (v > 8'hc0) ? 8'hc0 : v;
    return 8'h00;
  endfunction
  function automatic logic [7:0] exp_sf(input int m, input logic [7:0] v);
    if (m == 2 || m == 6) return (v > 8'h80) ? 8'h80 : v;
    return 8'h00;
  endfunction

  // single word transfer; waits on hready, never on a fixed count
  task automatic bus(input logic w, input logic [9:0] idx,
                     input logic [31:0] wd, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= {20'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask

  task automatic pulse_sysref();
    sysref <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sysref <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  // one-cycle sysref pulse; returns one edge after the capture edge
  task automatic sref_rise();
    sysref <= 1'b1;
    @(posedge clk_sys);
    t_cap = cyc;
    sysref <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    wrap_up();
  end

  initial begin
    seed = $urandom(32'h1ecf2f15);
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    // reset values, then read-only and reserved bits
    bus(0, IDX_STATUS, 0, rd);    `CHK("status rst", 32'h0, rd)
    bus(0, IDX_MODE, 0, rd);      `CHK("mode rst", 32'h0, rd)
    bus(0, IDX_SUPERFINE, 0, rd); `CHK("sf rst", 32'h0, rd)
    bus(0, IDX_FINE, 0, rd);      `CHK("fine rst", 32'h0, rd)
    bus(1, IDX_STATUS, 32'hf, rd);
    bus(0, IDX_STATUS, 0, rd);    `CHK("status ro", 32'h0, rd)
    bus(0, 10'h200, 0, rd);       `CHK("unmapped", 32'h0, rd)
    bus(1, IDX_SYNC_CTRL, 32'hff, rd);
    bus(0, IDX_SYNC_CTRL, 0, rd); `CHK("sync ctrl", 32'h8f, rd)
    // every mode code with clamp corners and random step values
    for (int m = 0; m < 8; m++) begin
      for (int k = 0; k < 3; k++) begin
        f = 8'($urandom_range(0, 192));
        s = 8'($urandom_range(0, 128));
        if (k < 2) f = (k == 0) ? 8'h11 : 8'hc1;
        if (k < 2) s = (k == 0) ? 8'h81 : 8'h80;
        bus(1, IDX_FINE, {24'h0, f}, rd);
        bus(1, IDX_SUPERFINE, {24'h0, s}, rd);
        bus(1, IDX_MODE, 32'(m) | 32'hf8, rd);
        repeat (2) @(posedge clk_sys);
        `CHK("fine_en", (m inside {2, 3, 4, 6}), fine_en)
        `CHK("sf_en", (m inside {2, 6}), superfine_en)
        `CHK("low_jitter", (m == 3), low_jitter)
        `CHK("fine_steps", exp_fine(m, f), fine_steps)
        `CHK("sf_steps", exp_sf(m, s), superfine_steps)
        `CHK("delay_fs", 19'(exp_fine(m, f) * 1725 + exp_sf(m, s) * 250),
             delay_fs)
        bus(0, IDX_MODE, 0, rd);  `CHK("mode rd", 32'(m), rd)
        bus(0, IDX_FINE, 0, rd);  `CHK("fine rd", {24'h0, f}, rd)
      end
    end
    // capture with both skew windows zero reports the phase offset
    bus(1, IDX_SYNC_CTRL, 32'h80, rd);
    for (int k = 0; k < 4; k++) begin
      ofs = {1'($urandom_range(0, 1)), 3'($urandom_range(1, 7))};
      bus(1, IDX_OFFSET, {28'h0, ofs}, rd);
      repeat (k) @(posedge clk_sys);
      pulse_sysref();
      bus(0, IDX_STATUS, 0, rd);  `CHK("status", {28'h0, ofs}, rd)
    end
    // capture disabled: a sysref edge leaves the status untouched
    bus(1, IDX_SYNC_CTRL, 32'h00, rd);
    bus(1, IDX_OFFSET, 32'h0, rd);
    pulse_sysref();
    bus(0, IDX_STATUS, 0, rd);    `CHK("status hold", {28'h0, ofs}, rd)
    // two zero-window edges five cycles apart leave the divider aligned
    bus(1, IDX_OFFSET, 32'h6, rd);
    bus(1, IDX_SYNC_CTRL, 32'h80, rd);
    sref_rise();
    repeat (3) @(posedge clk_sys);
    sref_rise();
    `CHK("align pulse", 1'b1, div_realign)
    `CHK("align phase", 4'h0, div_phase)
    a_edge = t_cap;
    // negative 2, positive 1, offset 6: each status is the offset, plus the phase if the edge is ignored
    bus(1, IDX_SYNC_CTRL, 32'h89, rd);
    for (int j = 0; j < 32; j++) begin
      repeat ($urandom_range(0, 7)) @(posedge clk_sys);
      sref_rise();
      ph = 4'(2 * (t_cap - a_edge - 1));
      win = (ph <= 4'h1) || (ph >= 4'he);
      `CHK("realign", !win, div_realign)
      `CHK("div_phase", (win ? 4'(ph + 2) : 4'h0), div_phase)
      if (!win) a_edge = t_cap;
      bus(0, IDX_STATUS, 0, rd);
      `CHK("status win", {28'h0, (win ? 4'(ph + 6) : 4'h6)}, rd)
    end
    wrap_up();
  end
endmodule
`default_nettype wire
